//--- verif/cdsx_exec_assertions.sv
`timescale 1ns/1ps
module cdsx_exec_assertions (
  input wire logic I_MCLK, // clock
  input wire logic I_NRST, // reset
  input wire logic [7:0] I_RD_DATA, // read data
  input wire logic [6:0] O_RD_IDX, // read index
  input wire logic O_RD_EN, // read strobe
  input wire logic [6:0] O_WR_IDX, // write index
  input wire logic [7:0] O_WR_DATA, // write data
  input wire logic O_WR_EN, // write strobe
  input wire logic [7:0] O_ACC, // accumulator
  input wire logic O_ZERO_WE, // zero strobe
  input wire logic O_ZERO, // zero value
  input wire logic O_SKIP, // skip slot
  input wire logic [1:0] O_QPHASE // quarter
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_NRST);
  a_phase_step: assert property (1 |=>
    O_QPHASE == $past(O_QPHASE) + 2'h1)
    else $error("quarter phase did not advance");
  a_read_phase: assert property (O_RD_EN |-> O_QPHASE == 2'h1)
    else $error("read strobe outside quarter two");
  a_write_after_read: assert property (O_WR_EN |->
    O_QPHASE == 2'h3 && $past(O_RD_EN, 2) &&
    O_WR_IDX == $past(O_RD_IDX, 2))
    else $error("write not tied to read");
  a_invert_value: assert property (O_WR_EN && O_ZERO_WE |->
    O_WR_DATA == ~$past(I_RD_DATA, 2)) else $error("bad inverse");
  a_dec_value: assert property (O_WR_EN && !O_ZERO_WE |->
    O_WR_DATA == $past(I_RD_DATA, 2) - 8'h01) else $error("bad decrement");
  a_zero_flag: assert property (O_ZERO_WE |-> O_ZERO ==
    ((O_WR_EN ? O_WR_DATA : O_ACC) == 8'h00)) else $error("bad zero flag");
  a_acc_update: assert property (!$stable(O_ACC) |->
    O_QPHASE == 2'h3 && !O_WR_EN) else $error("stray acc change");
  a_skip_quiet: assert property (O_SKIP |->
    !(O_RD_EN || O_WR_EN || O_ZERO_WE)) else $error("activity in skip");
  a_skip_span: assert property ($rose(O_SKIP) |->
    (O_QPHASE == 2'h0) ##0 O_SKIP [*4]) else $error("short skip cycle");
  c_skip: cover property ($rose(O_SKIP));
  c_zero_set: cover property (O_ZERO_WE && O_ZERO);
  c_dec_write: cover property (O_WR_EN && !O_ZERO_WE);
endmodule
bind cdsx_exec cdsx_exec_assertions u_chk (.*);

//--- verif/cdsx_regfile.sv
`timescale 1ns/1ps
module cdsx_regfile (
  input wire logic i_clk, // core clock
  input wire logic [6:0] i_rd_idx, // read index
  input wire logic i_rd_en, // read strobe
  input wire logic [6:0] i_wr_idx, // write index
  input wire logic [7:0] i_wr_data, // write data
  input wire logic i_wr_en, // write strobe
  output logic [7:0] o_rd_data // read data
);
  logic [7:0] mem [128];
  logic tog = 1'b0;
  // Idle data toggles so a late sample never looks valid
  assign o_rd_data = i_rd_en ? mem[i_rd_idx] : {8{tog}};
  always @(posedge i_clk)
  begin
    tog <= ~tog;
    if (i_wr_en)
      mem[i_wr_idx] <= i_wr_data;
  end
endmodule

//--- verif/complement_and_decrement_skip_exec_bench.sv
`timescale 1ns/1ps
module complement_and_decrement_skip_exec_bench;
  import cdsx_pkg::*;
  logic I_MCLK = 1'b0;
  logic I_NRST = 1'b0;
  logic [13:0] I_INSN = 14'h0000;
  logic [7:0] I_RD_DATA, O_WR_DATA, O_ACC;
  logic [6:0] O_RD_IDX, O_WR_IDX;
  logic O_RD_EN, O_WR_EN, O_ZERO_WE, O_ZERO, O_SKIP;
  logic [1:0] O_QPHASE;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;
  cdsx_exec dut (.*);
  cdsx_regfile rf (.i_clk(I_MCLK), .i_rd_idx(O_RD_IDX), .i_rd_en(O_RD_EN),
    .i_wr_idx(O_WR_IDX), .i_wr_data(O_WR_DATA), .i_wr_en(O_WR_EN),
    .o_rd_data(I_RD_DATA));
  initial forever #2.5 I_MCLK = ~I_MCLK;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge I_MCLK)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Issue one word in the slot that opens at the next quarter one
  task automatic run(input logic [5:0] op, input logic d,
    input logic [6:0] f);
    while (O_QPHASE !== 2'h3)
      @(negedge I_MCLK);
    I_INSN = {op, d, f};
    repeat (4) @(negedge I_MCLK);
    I_INSN = 14'h0000;
  endtask
  task automatic t_invert();
    rf.mem[5] = 8'h13;
    rf.mem[6] = 8'hff;
    run(OP_INVERT, 1'b0, 7'h05);
    chk(O_ACC, 8'hec);
    chk(O_ZERO, 8'h00);
    run(OP_INVERT, 1'b1, 7'h05);
    run(OP_INVERT, 1'b0, 7'h06);
    chk(rf.mem[5], 8'hec);
    chk(O_ACC, 8'h00);
    chk(O_ZERO, 8'h01);
  endtask
  task automatic t_dec_skip();
    rf.mem[9] = 8'h02;
    run(OP_DEC_SKIP, 1'b1, 7'h09);
    run(OP_INVERT, 1'b0, 7'h09);
    chk(rf.mem[9], 8'h01);
    chk(O_ACC, 8'hfe);
    chk(O_SKIP, 8'h00);
    run(OP_DEC_SKIP, 1'b0, 7'h09);
    chk(O_ACC, 8'h00);
    chk(O_ZERO, 8'h00);
    run(OP_INVERT, 1'b1, 7'h09);
    chk(O_SKIP, 8'h01);
    run(OP_INVERT, 1'b0, 7'h09);
    chk(rf.mem[9], 8'h01);
    chk(O_ACC, 8'hfe);
    chk(O_SKIP, 8'h00);
  endtask
  initial
  begin
    repeat (12) @(negedge I_MCLK);
    I_NRST = 1'b1;
    t_invert();
    t_dec_skip();
    give_verdict();
  end
endmodule

//--- verilog/cdsx_exec.sv
`timescale 1ns/1ps
// Contract
// - Opcode 001001 inverts the indexed register and updates zero.
// - Invert: select 0 writes accumulator, select 1 writes register.
// - Invert takes one word, one cycle: decode, read, compute, write.
// - Opcode 001011 decrements the indexed register; no flag changes.
// - Decrement: select 0 writes accumulator, select 1 writes register.
// - Zero result discards next word; a whole no-operation cycle follows.
// - Nonzero result runs the next word normally in one cycle.
module cdsx_exec
  import cdsx_pkg::*;
(
  input wire logic I_MCLK, // core clock
  input wire logic I_NRST, // async reset, active low
  input wire logic [13:0] I_INSN, // fetched instruction word
  input wire logic [7:0] I_RD_DATA, // register file read data
  output logic [6:0] O_RD_IDX, // register file read index
  output logic O_RD_EN, // read strobe in quarter two
  output logic [6:0] O_WR_IDX, // register file write index
  output logic [7:0] O_WR_DATA, // register file write data
  output logic O_WR_EN, // write strobe in quarter four
  output logic [7:0] O_ACC, // working accumulator
  output logic O_ZERO_WE, // zero flag update strobe
  output logic O_ZERO, // zero flag value
  output logic O_SKIP, // current cycle is a discarded slot
  output logic [1:0] O_QPHASE // current quarter phase
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic op_is(input logic [13:0] w, input logic [5:0] op);
    return w[OP_MSB:OP_LSB] == op;
  endfunction

  function automatic logic is_null(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  // ----------------------------------------------------------------
  // Quarter phase sequencer
  // ----------------------------------------------------------------
  quarter_t q_ff, nxt_q;

  always_comb
  begin
    nxt_q = quarter_t'(q_ff + 2'h1);
  end

  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
      q_ff <= QP_ONE;
    else
      q_ff <= nxt_q;
  end

  // ----------------------------------------------------------------
  // Execution datapath
  // ----------------------------------------------------------------
  logic [13:0] insn_ff, nxt_insn;
  logic is_inv_ff, nxt_is_inv;
  logic is_dec_ff, nxt_is_dec;
  logic skip_ff, nxt_skip;
  logic pend_skip_ff, nxt_pend_skip;
  logic [7:0] res_ff, nxt_res;
  logic [7:0] acc_ff, nxt_acc;
  logic [6:0] rd_idx_ff, nxt_rd_idx;
  logic rd_en_ff, nxt_rd_en;
  logic [6:0] wr_idx_ff, nxt_wr_idx;
  logic [7:0] wr_data_ff, nxt_wr_data;
  logic wr_en_ff, nxt_wr_en;
  logic zwe_ff, nxt_zwe;
  logic zero_ff, nxt_zero;

  always_comb
  begin
    nxt_insn = insn_ff;
    nxt_is_inv = is_inv_ff;
    nxt_is_dec = is_dec_ff;
    nxt_res = res_ff;
    nxt_acc = acc_ff;
    nxt_rd_idx = rd_idx_ff;
    nxt_rd_en = 1'b0;
    nxt_wr_idx = wr_idx_ff;
    nxt_wr_data = wr_data_ff;
    nxt_wr_en = 1'b0;
    nxt_zwe = 1'b0;
    nxt_zero = zero_ff;
    case (nxt_q)
      QP_ONE:
      begin
        // Decode; a word taken while a skip is pending is discarded
        nxt_insn = I_INSN;
        nxt_is_inv = !pend_skip_ff &&
          op_is(I_INSN, OP_INVERT);
        nxt_is_dec = !pend_skip_ff &&
          op_is(I_INSN, OP_DEC_SKIP);
        nxt_rd_idx = I_INSN[IDX_W-1:0];
      end

      QP_TWO:
      begin
        nxt_rd_en = is_inv_ff || is_dec_ff;
      end

      QP_THREE:
      begin
        // Operand is taken while the read strobe still stands
        if (is_inv_ff)
          nxt_res = ~I_RD_DATA;
        else
          nxt_res = I_RD_DATA - 8'h01;
      end

      QP_FOUR:
      begin
        if (is_inv_ff || is_dec_ff)
        begin
          if (insn_ff[DEST_BIT] == DEST_ACC)
            nxt_acc = res_ff;
          else
          begin
            nxt_wr_en = 1'b1;
            nxt_wr_idx = insn_ff[IDX_W-1:0];
            nxt_wr_data = res_ff;
          end
        end
        if (is_inv_ff)
        begin
          nxt_zwe = 1'b1;
          nxt_zero = is_null(res_ff);
        end
      end

      default:
      begin
        nxt_rd_en = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Datapath registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      insn_ff <= '0;
      is_inv_ff <= 1'b0;
      is_dec_ff <= 1'b0;
      res_ff <= 8'h00;
      acc_ff <= ACC_RST;
      rd_idx_ff <= 7'h00;
      rd_en_ff <= 1'b0;
      wr_idx_ff <= 7'h00;
      wr_data_ff <= 8'h00;
      wr_en_ff <= 1'b0;
      zwe_ff <= 1'b0;
      zero_ff <= 1'b0;
    end
    else
    begin
      insn_ff <= nxt_insn;
      is_inv_ff <= nxt_is_inv;
      is_dec_ff <= nxt_is_dec;
      res_ff <= nxt_res;
      acc_ff <= nxt_acc;
      rd_idx_ff <= nxt_rd_idx;
      rd_en_ff <= nxt_rd_en;
      wr_idx_ff <= nxt_wr_idx;
      wr_data_ff <= nxt_wr_data;
      wr_en_ff <= nxt_wr_en;
      zwe_ff <= nxt_zwe;
      zero_ff <= nxt_zero;
    end
  end

  // ----------------------------------------------------------------
  // Skip control
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_skip = skip_ff;
    nxt_pend_skip = pend_skip_ff;
    if (nxt_q == QP_ONE)
    begin
      // The armed skip covers all four quarters of the next cycle
      nxt_skip = pend_skip_ff;
      nxt_pend_skip = 1'b0;
    end
    // Decrement touches no flag; a zero result only arms the skip
    else if (nxt_q == QP_FOUR && is_dec_ff)
      nxt_pend_skip = is_null(res_ff);
  end

  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      skip_ff <= 1'b0;
      pend_skip_ff <= 1'b0;
    end
    else
    begin
      skip_ff <= nxt_skip;
      pend_skip_ff <= nxt_pend_skip;
    end
  end

  // ----------------------------------------------------------------
  // Output ports
  // ----------------------------------------------------------------
  assign O_RD_IDX = rd_idx_ff;
  assign O_RD_EN = rd_en_ff;
  assign O_WR_IDX = wr_idx_ff;
  assign O_WR_DATA = wr_data_ff;
  assign O_WR_EN = wr_en_ff;
  assign O_ACC = acc_ff;
  assign O_ZERO_WE = zwe_ff;
  assign O_ZERO = zero_ff;
  assign O_SKIP = skip_ff;
  assign O_QPHASE = q_ff;

endmodule

//--- verilog/cdsx_pkg.sv
package cdsx_pkg;
  // ----------------------------------------------------------------
  // Instruction word layout
  // ----------------------------------------------------------------
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int IDX_W = 7;
  localparam int OP_MSB = 13;
  localparam int OP_LSB = 8;
  localparam int DEST_BIT = 7;
  localparam logic [5:0] OP_INVERT = 6'h09;
  localparam logic [5:0] OP_DEC_SKIP = 6'h0b;
  localparam logic DEST_ACC = 1'h0;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [1:0] QCNT_RST = 2'h0;
  typedef enum logic [1:0] {
    QP_ONE = 2'b00,
    QP_TWO = 2'b01,
    QP_THREE = 2'b10,
    QP_FOUR = 2'b11
  } quarter_t;
endpackage
